// file: core/serial_port_pkg.sv
// Purpose: Constants and carrier types for the serial control port registers.
// Assumes: 16-bit instructions; register address is 13 bits wide.
package serial_port_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [12:0] ADDR_CONFIG = 13'h000;
  localparam logic [12:0] ADDR_VARIANT = 13'h003;
  localparam logic [12:0] ADDR_READBACK = 13'h004;
  localparam logic [12:0] ADDR_VCO_DIV = 13'h1e0;
  localparam logic [12:0] ADDR_CLK_IN = 13'h1e1;
  localparam logic [12:0] ADDR_PD_SYNC = 13'h230;
  localparam logic [12:0] ADDR_UPDATE = 13'h232;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CONFIG_RST = 8'h18;
  localparam logic [7:0] READBACK_RST = 8'h00;
  localparam logic [7:0] VCO_DIV_RST = 8'h02;
  localparam logic [7:0] CLK_IN_RST = 8'h00;
  localparam logic [7:0] PD_SYNC_RST = 8'h00;
  localparam logic [7:0] UPDATE_RST = 8'h00;
  // Arbitrary neutral value, not tied to any real part
  localparam logic [7:0] VARIANT_ID_DEFAULT = 8'ha5;

  // ==========================================================
  // Field positions
  localparam int CFG_PIN_SEL_BIT = 0;
  localparam int CFG_LSB_FIRST_BIT = 1;
  localparam int CFG_SOFT_RST_BIT = 2;
  localparam int CFG_LONG_INSTR_BIT = 3;
  localparam logic [7:0] CFG_SOFT_RST_KEEP = 8'h24;
  localparam int READBACK_ACTIVE_BIT = 0;
  localparam int UPDATE_BIT = 0;
  localparam int INSTR_RW_BIT = 15;
  localparam int INSTR_LEN_MSB = 14;
  localparam int INSTR_LEN_LSB = 13;

  // ==========================================================
  // Counts
  localparam logic [4:0] INSTR_LAST_BIT = 5'd15;
  localparam logic [2:0] BYTE_LAST_BIT = 3'd7;
  localparam logic [1:0] LEN_STREAM = 2'b11;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA = 2'b10,
    ST_DONE = 2'b11
  } port_state_t;

  typedef struct packed {
    logic csb_n;
    logic sclk;
    logic sdio;
  } serial_pins_t;

  typedef struct packed {
    logic [7:0] vco_div;
    logic [7:0] clk_in;
    logic [7:0] pd_sync;
  } active_regs_t;

endpackage : serial_port_pkg

// file: core/serial_port_config_regs.sv
// Purpose: Serial control port slave with configuration and buffered registers.
// Assumes: Port pins are asynchronous to clk and are sampled by it.
// Notes: Port control bits act at once; device registers act on update.
`timescale 1ns/1ps

module serial_port_config_regs
#(
  parameter logic [7:0] VARIANT_ID = serial_port_pkg::VARIANT_ID_DEFAULT
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire serial_port_pkg::serial_pins_t pins,
  output logic sdio_data,
  output logic sdio_oe,
  output logic serial_output_pin,
  output logic serial_output_pin_oe,
  output serial_port_pkg::active_regs_t active_regs,
  output logic [7:0] port_config
);
  import serial_port_pkg::*;

  // ==========================================================
  // Pin synchronisers
  serial_pins_t pins_s1_q;
  serial_pins_t pins_s2_q;
  logic sclk_prev_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_act;

  // Two stages before anything reads the pins
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pins_s1_q <= '{csb_n: 1'b1, sclk: 1'b0, sdio: 1'b0};
      pins_s2_q <= '{csb_n: 1'b1, sclk: 1'b0, sdio: 1'b0};
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      pins_s1_q <= pins;
      pins_s2_q <= pins_s1_q;
      sclk_prev_q <= pins_s2_q.sclk;
    end
  end

  // Edge detection on the synchronised clock only
  assign sclk_rise = pins_s2_q.sclk & ~sclk_prev_q;
  assign sclk_fall = ~pins_s2_q.sclk & sclk_prev_q;
  assign cs_act = ~pins_s2_q.csb_n;

  // ==========================================================
  // Register storage
  logic [7:0] cfg_q;
  logic [7:0] rb_sel_q;
  logic [7:0] vco_buf_q;
  logic [7:0] clk_buf_q;
  logic [7:0] pd_buf_q;
  logic [7:0] upd_q;
  active_regs_t act_q;
  logic lsb_first;
  logic soft_rst;

  assign lsb_first = cfg_q[CFG_LSB_FIRST_BIT];
  assign soft_rst = cfg_q[CFG_SOFT_RST_BIT];

  // ==========================================================
  // Serial framing
  port_state_t state_q;
  logic [15:0] sh_q;
  logic [15:0] sh_d;
  logic [4:0] icnt_q;
  logic [2:0] bcnt_q;
  logic [12:0] addr_q;
  logic [1:0] left_q;
  logic stream_q;
  logic rd_q;
  logic [7:0] tx_q;
  logic rd_drive_q;
  logic dout_q;
  logic we_q;
  logic [12:0] wa_q;
  logic [7:0] wd_q;
  logic [7:0] rdata;

  // Incoming bit placed by the selected order
  always_comb
  begin
    if (lsb_first)
      sh_d = {pins_s2_q.sdio, sh_q[15:1]};
    else
      sh_d = {sh_q[14:0], pins_s2_q.sdio};
  end

  // Read mux: bank chosen by readback select
  always_comb
  begin
    rdata = 8'h00;
    case (addr_q)
      ADDR_CONFIG: rdata = cfg_q;
      ADDR_VARIANT: rdata = VARIANT_ID;
      ADDR_READBACK: rdata = rb_sel_q;
      ADDR_VCO_DIV:
        rdata = rb_sel_q[READBACK_ACTIVE_BIT] ? act_q.vco_div : vco_buf_q;
      ADDR_CLK_IN:
        rdata = rb_sel_q[READBACK_ACTIVE_BIT] ? act_q.clk_in : clk_buf_q;
      ADDR_PD_SYNC:
        rdata = rb_sel_q[READBACK_ACTIVE_BIT] ? act_q.pd_sync : pd_buf_q;
      ADDR_UPDATE: rdata = upd_q;
      default: rdata = 8'h00;
    endcase
  end

  // Frame state: instruction, data bytes, then wait for deselect
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      sh_q <= 16'h0000;
      icnt_q <= 5'd0;
      bcnt_q <= 3'd0;
      addr_q <= 13'h0000;
      left_q <= 2'b00;
      stream_q <= 1'b0;
      rd_q <= 1'b0;
      we_q <= 1'b0;
      wa_q <= 13'h0000;
      wd_q <= 8'h00;
    end
    else
    begin
      we_q <= 1'b0;
      if (!cs_act)
      begin
        state_q <= ST_IDLE;
        icnt_q <= 5'd0;
        bcnt_q <= 3'd0;
      end
      else if (sclk_rise)
      begin
        sh_q <= sh_d;
        case (state_q)
          ST_IDLE, ST_INSTR:
          begin
            // Always a 16-bit instruction; length bit is not consulted
            if (icnt_q == INSTR_LAST_BIT)
            begin
              rd_q <= sh_d[INSTR_RW_BIT];
              left_q <= sh_d[INSTR_LEN_MSB:INSTR_LEN_LSB];
              stream_q <= (sh_d[INSTR_LEN_MSB:INSTR_LEN_LSB] == LEN_STREAM);
              addr_q <= sh_d[12:0];
              bcnt_q <= 3'd0;
              state_q <= ST_DATA;
            end
            else
            begin
              icnt_q <= icnt_q + 5'd1;
              state_q <= ST_INSTR;
            end
          end
          ST_DATA:
          begin
            bcnt_q <= bcnt_q + 3'd1;
            if (bcnt_q == BYTE_LAST_BIT)
            begin
              if (!rd_q)
              begin
                we_q <= 1'b1;
                wa_q <= addr_q;
                wd_q <= lsb_first ? sh_d[15:8] : sh_d[7:0];
              end
              // Step address per byte by bit order
              if (lsb_first)
                addr_q <= addr_q + 13'd1;
              else
                addr_q <= addr_q - 13'd1;
              if (!stream_q && left_q == 2'b00)
                state_q <= ST_DONE;
              else if (!stream_q)
                left_q <= left_q - 2'b01;
            end
          end
          ST_DONE: state_q <= ST_DONE;
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Read data launch on falling edges
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_q <= 8'h00;
      dout_q <= 1'b0;
      rd_drive_q <= 1'b0;
    end
    else if (!cs_act)
    begin
      rd_drive_q <= 1'b0;
    end
    else if (sclk_fall && state_q == ST_DATA && rd_q)
    begin
      rd_drive_q <= 1'b1;
      if (bcnt_q == 3'd0)
      begin
        // Fetch at byte start so address steps are seen
        dout_q <= lsb_first ? rdata[0] : rdata[7];
        tx_q <= lsb_first ? {1'b0, rdata[7:1]} : {rdata[6:0], 1'b0};
      end
      else
      begin
        dout_q <= lsb_first ? tx_q[0] : tx_q[7];
        tx_q <= lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
      end
    end
    else if (sclk_fall && state_q == ST_DONE)
    begin
      rd_drive_q <= 1'b0;
    end
  end

  // ==========================================================
  // Pin drivers; registered so outputs come from flip-flops
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sdio_data <= 1'b0;
      sdio_oe <= 1'b0;
      serial_output_pin <= 1'b0;
      serial_output_pin_oe <= 1'b0;
    end
    else
    begin
      sdio_data <= dout_q;
      sdio_oe <= rd_drive_q & ~cfg_q[CFG_PIN_SEL_BIT];
      serial_output_pin <= dout_q;
      // Output pin stays released unless unidirectional mode
      serial_output_pin_oe <= cs_act & cfg_q[CFG_PIN_SEL_BIT];
    end
  end

  // ==========================================================
  // Port control registers act immediately
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_q <= CONFIG_RST;
      rb_sel_q <= READBACK_RST;
    end
    else if (we_q && wa_q == ADDR_CONFIG)
    begin
      // Host is trusted to mirror the nibbles
      cfg_q <= wd_q;
    end
    else if (soft_rst)
    begin
      // Bit stays set until the host writes it clear
      cfg_q <= CONFIG_RST | (cfg_q & CFG_SOFT_RST_KEEP);
      rb_sel_q <= READBACK_RST;
    end
    else if (we_q && wa_q == ADDR_READBACK)
    begin
      rb_sel_q <= {7'h00, wd_q[READBACK_ACTIVE_BIT]};
    end
  end

  // Buffer copies: serial writes land only here
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      vco_buf_q <= VCO_DIV_RST;
      clk_buf_q <= CLK_IN_RST;
      pd_buf_q <= PD_SYNC_RST;
    end
    else if (soft_rst)
    begin
      vco_buf_q <= VCO_DIV_RST;
      clk_buf_q <= CLK_IN_RST;
      pd_buf_q <= PD_SYNC_RST;
    end
    else if (we_q)
    begin
      case (wa_q)
        ADDR_VCO_DIV: vco_buf_q <= wd_q;
        ADDR_CLK_IN: clk_buf_q <= wd_q;
        ADDR_PD_SYNC: pd_buf_q <= wd_q;
        default: vco_buf_q <= vco_buf_q;
      endcase
    end
  end

  // Update strobe: a new write wins over the self-clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      upd_q <= UPDATE_RST;
    else if (soft_rst)
      upd_q <= UPDATE_RST;
    else if (we_q && wa_q == ADDR_UPDATE && wd_q[UPDATE_BIT])
      upd_q <= 8'h01;
    else
      upd_q <= UPDATE_RST;
  end

  // Active copies change only on update transfer or soft reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      act_q <= '{vco_div: VCO_DIV_RST, clk_in: CLK_IN_RST, pd_sync: PD_SYNC_RST};
    else if (soft_rst)
      act_q <= '{vco_div: VCO_DIV_RST, clk_in: CLK_IN_RST, pd_sync: PD_SYNC_RST};
    else if (upd_q[UPDATE_BIT])
      act_q <= '{vco_div: vco_buf_q, clk_in: clk_buf_q, pd_sync: pd_buf_q};
  end

  // ==========================================================
  // Outputs
  assign active_regs = act_q;
  assign port_config = cfg_q;

endmodule : serial_port_config_regs

// file: verification/spcr_chk.sv
// Purpose: Port-level checks for the serial port register block.
// Assumes: Host moves its pins on falling clk edges, 16 clk per sclk.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps

module spcr_chk
(
  input wire logic clk,
  input wire logic rstn,
  input wire serial_port_pkg::serial_pins_t pins,
  input wire logic sdio_data,
  input wire logic sdio_oe,
  input wire logic serial_output_pin,
  input wire logic serial_output_pin_oe,
  input wire serial_port_pkg::active_regs_t active_regs,
  input wire logic [7:0] port_config
);
  import serial_port_pkg::*;
  // ==========================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_reset_config: assert property ($rose(rstn) |-> port_config == CONFIG_RST)
    else $error("config not at default after reset");
  a_pins_exclusive: assert property (!(sdio_oe && serial_output_pin_oe))
    else $error("both data outputs driven");
  a_idle_release: assert property (pins.csb_n [*6] |-> !sdio_oe && !serial_output_pin_oe)
    else $error("output still driven while deselected");
  a_bidir_mode: assert property (sdio_oe |-> !port_config[0])
    else $error("data pin driven in unidirectional mode");
  a_unidir_start: assert property ($rose(serial_output_pin_oe) |-> port_config[0])
    else $error("output pin driven in bidirectional mode");
  // Enable is registered, so it follows the select one cycle late
  a_unidir_only: assert property (serial_output_pin_oe |-> $past(port_config[0]))
    else $error("output pin enabled while not selected");
  a_oe_frame: assert property (sdio_oe |-> !$past(pins.csb_n, 6))
    else $error("data pin driven outside a frame");
  a_bit_launch: assert property (sdio_oe && $changed(sdio_data) |-> !$past(pins.sclk, 3))
    else $error("read bit changed away from falling edge");
  a_out_launch: assert property (serial_output_pin_oe && $changed(serial_output_pin)
    |-> !$past(pins.sclk, 3))
    else $error("output pin bit changed away from falling edge");
  a_active_frame: assert property ($changed(active_regs) |-> !$past(pins.csb_n, 3))
    else $error("active copy changed without a transfer");
  a_config_frame: assert property ($changed(port_config) |-> !$past(pins.csb_n, 3))
    else $error("config changed without a transfer");
  c_unidir: cover property ($rose(serial_output_pin_oe));
  c_read: cover property ($rose(sdio_oe));
  c_update: cover property ($changed(active_regs));
  c_soft: cover property ($rose(port_config[2]));
endmodule : spcr_chk

bind serial_port_config_regs spcr_chk chk (.clk(clk), .rstn(rstn), .pins(pins),
  .sdio_data(sdio_data), .sdio_oe(sdio_oe), .serial_output_pin(serial_output_pin),
  .serial_output_pin_oe(serial_output_pin_oe), .active_regs(active_regs),
  .port_config(port_config));

// file: verification/host_model.sv
// Purpose: Serial host controller driving frames into the block.
// Assumes: sclk idles low and runs 8 clk high, 8 clk low.
// Notes: Released data line shows the inverse of the last bit.
`timescale 1ns/1ps

module host_model
(
  input wire logic clk,
  input wire logic lsb,
  input wire logic um,
  input wire logic sdio_data,
  input wire logic sdio_oe,
  input wire logic sout,
  input wire logic sout_oe,
  output serial_port_pkg::serial_pins_t pins
);
  import serial_port_pkg::*;
  logic csb = 1'b1;
  logic sck = 1'b0;
  logic drv = 1'b1;
  logic hb = 1'b0;
  // ==========================================
  // Pin resolution, no kind default on a released line
  assign pins = '{csb_n: csb, sclk: sck, sdio: drv ? hb : (sdio_oe ? sdio_data : ~hb)};

  task automatic bit_x(input logic b, output logic r);
    if (drv)
      hb = b;
    repeat (8) @(negedge clk);
    sck = 1'b1;
    r = um ? (sout_oe ? sout : ~hb) : pins.sdio;
    repeat (8) @(negedge clk);
    sck = 1'b0;
  endtask : bit_x

  // Bytes travel in q/wd from bit 15 down, one per length step
  task automatic xfer(input logic rd, input logic [1:0] len, input logic [12:0] a,
    input logic [15:0] wd, output logic [15:0] q);
    logic [15:0] ins;
    logic r;
    ins = {rd, len, a};
    q = '0;
    @(negedge clk);
    csb = 1'b0;
    for (int i = 0; i < 16; i++)
      bit_x(ins[lsb ? i : 15 - i], r);
    drv = !rd;
    for (int k = 0; k <= len; k++)
      for (int i = 0; i < 8; i++)
      begin
        bit_x(wd[15 - 8 * k - (lsb ? 7 - i : i)], r);
        q[15 - 8 * k - (lsb ? 7 - i : i)] = r;
      end
    repeat (8) @(negedge clk);
    csb = 1'b1;
    drv = 1'b1;
    repeat (8) @(negedge clk);
  endtask : xfer
endmodule : host_model

// file: verification/tb.sv
// Purpose: Self-checking bench for the serial port register block.
// Assumes: Host model frames all traffic; checker is bound.
// Notes: Expected values come from the package constants and the data each test writes.
`timescale 1ns/1ps

module tb;
  import serial_port_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic lsb = 1'b0;
  logic um = 1'b0;
  serial_pins_t pins;
  logic sdio_data;
  logic sdio_oe;
  logic sout;
  logic sout_oe;
  active_regs_t act;
  logic [7:0] cfg;
  logic [15:0] q;
  int n_fail = 0;
  int n_tests = 0;
  // ==========================================
  // Clock and instances
  initial
    forever #2.5 clk = ~clk;
  serial_port_config_regs dut (.clk(clk), .rstn(rstn), .pins(pins), .sdio_data(sdio_data),
    .sdio_oe(sdio_oe), .serial_output_pin(sout), .serial_output_pin_oe(sout_oe),
    .active_regs(act), .port_config(cfg));
  host_model host (.clk(clk), .lsb(lsb), .um(um), .sdio_data(sdio_data), .sdio_oe(sdio_oe),
    .sout(sout), .sout_oe(sout_oe), .pins(pins));

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, 2'b00, a, {d, 8'h00}, q);
  endtask : wr

  task automatic rd(input logic [12:0] a);
    host.xfer(1'b1, 2'b00, a, 16'h0000, q);
  endtask : rd

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // ==========================================
  // Scenarios
  task automatic t_defaults();
    chk(cfg, CONFIG_RST);
    chk(act, {VCO_DIV_RST, CLK_IN_RST, PD_SYNC_RST});
    wr(ADDR_VARIANT, 8'h3c);
    rd(ADDR_VARIANT);
    chk(q[15:8], VARIANT_ID_DEFAULT);
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_update();
    wr(ADDR_VCO_DIV, 8'h05);
    chk(act.vco_div, VCO_DIV_RST);
    wr(ADDR_UPDATE, 8'h01);
    chk(act.vco_div, 8'h05);
    rd(ADDR_UPDATE);
    chk(q[15:8], 8'h00);
    wr(ADDR_VCO_DIV, 8'h07);
    wr(ADDR_READBACK, 8'h01);
    rd(ADDR_VCO_DIV);
    chk(q[15:8], 8'h05);
    wr(ADDR_READBACK, 8'h00);
    rd(ADDR_VCO_DIV);
    chk(q[15:8], 8'h07);
    $display("test update done");
  endtask : t_update

  // Two-byte frames show the address step in each order
  task automatic t_order();
    host.xfer(1'b0, 2'b01, ADDR_CLK_IN, 16'h210a, q);
    rd(ADDR_VCO_DIV);
    chk(q[15:8], 8'h0a);
    wr(ADDR_CONFIG, 8'h5a);
    lsb = 1'b1;
    host.xfer(1'b0, 2'b01, ADDR_VCO_DIV, 16'h3c44, q);
    host.xfer(1'b1, 2'b01, ADDR_VCO_DIV, 16'h0000, q);
    chk(q, 16'h3c44);
    wr(ADDR_CONFIG, 8'h18);
    lsb = 1'b0;
    rd(ADDR_CLK_IN);
    chk(q[15:8], 8'h44);
    $display("test order done");
  endtask : t_order

  task automatic t_unidir();
    wr(ADDR_CONFIG, 8'h99);
    um = 1'b1;
    rd(ADDR_VARIANT);
    chk(q[15:8], VARIANT_ID_DEFAULT);
    wr(ADDR_CONFIG, 8'h18);
    um = 1'b0;
    $display("test unidir done");
  endtask : t_unidir

  task automatic t_soft();
    wr(ADDR_PD_SYNC, 8'h03);
    wr(ADDR_UPDATE, 8'h01);
    chk(act.pd_sync, 8'h03);
    wr(ADDR_CONFIG, 8'h3c);
    chk(act, {VCO_DIV_RST, CLK_IN_RST, PD_SYNC_RST});
    chk(cfg, 8'h3c);
    wr(ADDR_CONFIG, 8'h18);
    chk(cfg, 8'h18);
    rd(ADDR_PD_SYNC);
    chk(q[15:8], PD_SYNC_RST);
    $display("test soft reset done");
  endtask : t_soft

  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_defaults();
    t_update();
    t_order();
    t_unidir();
    t_soft();
    tally_and_finish();
  end

  // Frames take about 2 us each; far fewer than the span allows
  initial
  begin
    #300000;
    n_fail++;
    tally_and_finish();
  end
endmodule : tb
